// [pkg/sup_pkg.sv]
// Constants, carrier types and register map of the enable pin and internal supervision block
// Behaviour
// - Enable falling edge raises class A event
// - Enable high valid, low holds block disabled
// - Floating enable reads low through pull-down
// - Enable rise clears fault outputs in modes three/five
// - Report enable level and validity separately
// - Other errors may keep block disabled
// - Send lifesign periodically, check counterpart window
// - Lifesign error: reset event, class B fault
// - Lifesign loss sets both communication error bits
// - Live secondary ready bit, separate from stickies
// - Supervise oscillators via lifesign and reference pins
// - Primary reference failure holds reset, asserts reset_ready
// - Secondary reference failure seen as lifesign loss
// - Configuration protected by continuously checked parity (the code acts on it only while in SUP_RUN)
// - Primary parity failure: permanent reset, secondary off
// - Secondary parity failure seen as lifesign loss
// - Primary oscillator absent: reset, fault, refuse bus
// - Secondary oscillator absent: fault, error, ready zero
// - Secondary oscillator misbehaves: fault, error, ready clear
// - Supervision always on, not software controllable
// - Class A fault only on mode four/six event
// - Fault and reset_ready outputs active low
// - Reset event restores defaults and initial mode
package sup_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int LIFESIGN_PERIOD_NS = 10000;
  localparam int LS_WINDOW_NS = 30000;
  localparam int LS_PERIOD_CYC = LIFESIGN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int LS_WINDOW_CYC = LS_WINDOW_NS / CLK_PERIOD_NS;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ERROR = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0C;

  localparam int CTRL_CLR_PRI = 0;
  localparam int CTRL_CLR_SEC = 1;

  localparam int STAT_EN_LEVEL = 0;
  localparam int STAT_EN_VALID = 1;
  localparam int STAT_SEC_READY = 2;
  localparam int STAT_FLTA = 3;
  localparam int STAT_FLTB = 4;
  localparam int STAT_RST_RDY = 5;
  localparam int STAT_DISABLED = 6;
  localparam int STAT_SUP_LSB = 8;

  localparam int ERR_PRI_COMM = 0;
  localparam int ERR_SEC_COMM = 1;
  localparam int ERR_PARITY = 2;
  localparam int ERR_REF = 3;
  localparam int ERR_NOSTART = 4;

  localparam int CFG_CLFA = 0;
  localparam int CFG_CLFB = 1;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic CFG_RESET_PAR = 1'b0;

  localparam logic [2:0] MODE_THIRD = 3'h3;
  localparam logic [2:0] MODE_FOURTH = 3'h4;
  localparam logic [2:0] MODE_FIFTH = 3'h5;
  localparam logic [2:0] MODE_SIXTH = 3'h6;

  typedef enum logic [3:0] {
    SUP_RUN = 4'h1,
    SUP_HOLD = 4'h2,
    SUP_DEAD = 4'h4,
    SUP_NOSTART = 4'h8
  } sup_state_t;

  typedef struct packed {
    logic enable_pin;
    logic lifesign_rx;
    logic pri_ref_fault;
    logic osc_running;
    logic [2:0] op_mode;
  } sup_in_t;

  typedef struct packed {
    logic class_a_fault_n;
    logic class_b_fault_n;
    logic reset_ready_n;
    logic lifesign_tx;
    logic class_a_event;
    logic reset_event;
    logic sec_emergency_off;
    logic device_disabled;
    logic bus_accept;
  } sup_out_t;

endpackage

// [logic/enable_supervisor.sv]
// Enable pin handling, lifesign watchdog and parity supervision with AHB-Lite registers
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module enable_supervisor import sup_pkg::*; #(
  parameter int LS_PERIOD = LS_PERIOD_CYC,
  parameter int LS_WINDOW = LS_WINDOW_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pins, link and mode
  input wire sup_in_t pins_in,
  output sup_out_t pins_out
);

  localparam int CW = 12;
  localparam logic [CW-1:0] TX_LAST = CW'(LS_PERIOD - 1);
  localparam logic [CW-1:0] RX_LAST = CW'(LS_WINDOW - 1);

  typedef struct packed {
    sup_state_t sup;
    logic en_s1;
    logic en_s2;
    logic en_prev;
    logic [CW-1:0] tx_cnt;
    logic [CW-1:0] rx_cnt;
    logic sec_ready;
    logic flta_n;
    logic fltb_n;
    logic rst_n;
    logic cls_a_evt;
    logic rst_evt;
    logic emerg_off;
    logic disabled;
    logic ls_tx;
    logic pri_comm;
    logic sec_comm;
    logic par_err;
    logic ref_err;
    logic nostart_err;
    logic [7:0] cfg;
    logic cfg_par;
    logic ph_wr;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
  } state_t;

  localparam state_t STATE_RST = '{
    sup: SUP_NOSTART,
    flta_n: 1'b1,
    fltb_n: 1'b1,
    cfg: CFG_RESET,
    cfg_par: CFG_RESET_PAR,
    default: '0
  };

  state_t r;
  state_t nxt;

  logic en_rise;
  logic en_fall;
  logic bus_go;
  logic par_bad;
  logic mode_a_trip;
  logic mode_a_clear;

  // Edges seen only on the synchronised copy, so one edge gives one event
  assign en_rise = r.en_s2 && !r.en_prev;
  assign en_fall = !r.en_s2 && r.en_prev;
  assign bus_go = hsel && hready && htrans[1];
  // Acted on only while sup is SUP_RUN; software has no way to mask it
  assign par_bad = (^r.cfg) != r.cfg_par;
  assign mode_a_trip = (pins_in.op_mode == MODE_FOURTH) || (pins_in.op_mode == MODE_SIXTH);
  assign mode_a_clear = (pins_in.op_mode == MODE_THIRD) || (pins_in.op_mode == MODE_FIFTH);

  function automatic logic [31:0] reg_read(input state_t s, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      OFS_STATUS: begin
        d[STAT_EN_LEVEL] = s.en_s2;
        d[STAT_EN_VALID] = s.en_s2;
        d[STAT_SEC_READY] = s.sec_ready;
        d[STAT_FLTA] = s.flta_n;
        d[STAT_FLTB] = s.fltb_n;
        d[STAT_RST_RDY] = s.rst_n;
        d[STAT_DISABLED] = s.disabled;
        d[STAT_SUP_LSB +: 4] = s.sup;
      end
      OFS_ERROR: begin
        d[ERR_PRI_COMM] = s.pri_comm;
        d[ERR_SEC_COMM] = s.sec_comm;
        d[ERR_PARITY] = s.par_err;
        d[ERR_REF] = s.ref_err;
        d[ERR_NOSTART] = s.nostart_err;
      end
      OFS_CONFIG: d[7:0] = s.cfg;
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  always_comb begin
    nxt = r;
    nxt.cls_a_evt = 1'b0;
    nxt.rst_evt = 1'b0;
    nxt.ls_tx = 1'b0;
    nxt.en_s1 = pins_in.enable_pin;
    nxt.en_s2 = r.en_s1;
    nxt.en_prev = r.en_s2;

    // Bus address phase; read data is prepared so it leaves a flip-flop
    nxt.ph_wr = bus_go && hwrite;
    nxt.ph_addr = haddr[7:0];
    if (bus_go && !hwrite) begin
      nxt.rdata = reg_read(r, haddr[7:0]);
    end

    // Data phase writes; refused unless the primary side is running
    if (r.ph_wr && r.sup == SUP_RUN) begin
      case (r.ph_addr)
        OFS_CTRL: begin
          if (hwdata[CTRL_CLR_PRI]) begin
            nxt.pri_comm = 1'b0;
            nxt.par_err = 1'b0;
            nxt.ref_err = 1'b0;
            nxt.nostart_err = 1'b0;
            if (!(r.cfg[CFG_CLFA] && !r.en_s2)) begin
              nxt.flta_n = 1'b1;
            end
            if (!(r.cfg[CFG_CLFB] && !r.sec_ready)) begin
              nxt.fltb_n = 1'b1;
            end
          end
          if (hwdata[CTRL_CLR_SEC]) begin
            nxt.sec_comm = 1'b0;
          end
        end
        OFS_CONFIG: begin
          nxt.cfg = hwdata[7:0];
          nxt.cfg_par = ^hwdata[7:0];
        end
        default: begin
        end
      endcase
    end

    // Enable events come after writes so a set beats a clear
    if (en_fall) begin
      nxt.cls_a_evt = 1'b1;
      if (mode_a_trip) begin
        nxt.flta_n = 1'b0;
      end
    end
    if (en_rise && mode_a_clear) begin
      nxt.flta_n = 1'b1;
      nxt.fltb_n = 1'b1;
    end

    case (r.sup)
      SUP_NOSTART: begin
        if (pins_in.osc_running) begin
          nxt.sup = SUP_RUN;
          nxt.rst_n = 1'b1;
          nxt.emerg_off = 1'b0;
        end else begin
          nxt.rst_n = 1'b0;
          nxt.fltb_n = 1'b0;
          nxt.emerg_off = 1'b1;
          nxt.nostart_err = 1'b1;
        end
      end
      SUP_RUN: begin
        if (par_bad) begin
          nxt.sup = SUP_DEAD;
          nxt.rst_n = 1'b0;
          nxt.fltb_n = 1'b0;
          nxt.emerg_off = 1'b1;
          nxt.par_err = 1'b1;
          nxt.rst_evt = 1'b1;
          nxt.sec_ready = 1'b0;
        end else if (pins_in.pri_ref_fault) begin
          nxt.sup = SUP_HOLD;
          nxt.rst_n = 1'b0;
          nxt.fltb_n = 1'b0;
          nxt.ref_err = 1'b1;
          nxt.rst_evt = 1'b1;
          nxt.sec_ready = 1'b0;
        end else begin
          if (r.tx_cnt == TX_LAST) begin
            nxt.tx_cnt = '0;
            nxt.ls_tx = 1'b1;
          end else begin
            nxt.tx_cnt = r.tx_cnt + 1'b1;
          end
          // A missing lifesign covers a dead, drifting or parity-failed secondary
          if (pins_in.lifesign_rx) begin
            nxt.rx_cnt = '0;
            nxt.sec_ready = 1'b1;
          end else if (r.rx_cnt == RX_LAST) begin
            nxt.rx_cnt = '0;
            nxt.sec_ready = 1'b0;
            nxt.pri_comm = 1'b1;
            nxt.sec_comm = 1'b1;
            nxt.fltb_n = 1'b0;
            nxt.rst_evt = 1'b1;
          end else begin
            nxt.rx_cnt = r.rx_cnt + 1'b1;
          end
        end
      end
      SUP_HOLD: begin
        nxt.rst_n = 1'b0;
        nxt.tx_cnt = '0;
        nxt.rx_cnt = '0;
        if (!pins_in.pri_ref_fault) begin
          nxt.sup = SUP_RUN;
          nxt.rst_n = 1'b1;
        end
      end
      SUP_DEAD: begin
        // Only a power reset leaves this state
        nxt.rst_n = 1'b0;
        nxt.emerg_off = 1'b1;
      end
      default: nxt.sup = SUP_NOSTART;
    endcase

    if (nxt.rst_evt) begin
      nxt.cfg = CFG_RESET;
      nxt.cfg_par = CFG_RESET_PAR;
    end
    nxt.disabled = !nxt.en_s2 || nxt.sup != SUP_RUN || !nxt.fltb_n;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= STATE_RST;
    end else begin
      r <= nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign pins_out.class_a_fault_n = r.flta_n;
  assign pins_out.class_b_fault_n = r.fltb_n;
  assign pins_out.reset_ready_n = r.rst_n;
  assign pins_out.lifesign_tx = r.ls_tx;
  assign pins_out.class_a_event = r.cls_a_evt;
  assign pins_out.reset_event = r.rst_evt;
  assign pins_out.sec_emergency_off = r.emerg_off;
  assign pins_out.device_disabled = r.disabled;
  assign pins_out.bus_accept = r.sup == SUP_RUN;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence seq_fall;
    r.en_prev && !r.en_s2;
  endsequence

  sequence seq_ls_loss;
    r.sup == SUP_RUN && !par_bad && !pins_in.pri_ref_fault && !pins_in.lifesign_rx
      && r.rx_cnt == RX_LAST;
  endsequence

  a_fall_event: assert property (seq_fall |=> r.cls_a_evt ##1 !r.cls_a_evt)
    else $error("enable fall gave no single class A event");
  a_flta_trip: assert property (seq_fall ##0 mode_a_trip |=> !r.flta_n)
    else $error("class A fault not raised in mode four or six");
  a_flta_quiet: assert property ($fell(r.flta_n) |-> $past(en_fall))
    else $error("class A fault raised without enable fall");
  a_rise_clear: assert property (en_rise && mode_a_clear |=> r.flta_n)
    else $error("enable rise did not clear class A fault");
  a_ls_loss: assert property (seq_ls_loss |=> !r.fltb_n && r.pri_comm
    && r.sec_comm && !r.sec_ready && r.rst_evt)
    else $error("lifesign loss reaction missing");
  a_tx_period: assert property (r.ls_tx |-> r.tx_cnt == '0 ##1 !r.ls_tx)
    else $error("lifesign pulse malformed");
  a_hold_reset: assert property (r.sup == SUP_HOLD |-> !pins_out.reset_ready_n)
    else $error("reset_ready released during reference failure");
  a_dead_stays: assert property (r.sup == SUP_DEAD |=> r.sup == SUP_DEAD
    && !r.rst_n && r.emerg_off)
    else $error("parity failure state left");
  a_cfg_default: assert property (r.rst_evt |-> r.cfg == CFG_RESET)
    else $error("reset event kept configuration");
  a_refuse_write: assert property (r.ph_wr && r.sup != SUP_RUN && !nxt.rst_evt
    |=> $stable(r.cfg))
    else $error("write taken while primary held in reset");

endmodule

// [verif/secondary_model.sv]
// Behavioural secondary chip sending periodic lifesign pulses to the primary side
`timescale 1ns/1ps
module secondary_model #(
  parameter int PERIOD = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Health of the secondary chip, set by the bench
  input wire logic alive,
  // Link towards the primary side
  output logic lifesign_rx
);
  int cnt_r;
  // A failed secondary sits in reset, so the link goes quiet
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 0;
      lifesign_rx <= 1'b0;
    end else if (!alive) begin
      cnt_r <= 0;
      lifesign_rx <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
      lifesign_rx <= (cnt_r == PERIOD - 1);
    end
  end
endmodule

// [verif/enable_supervisor_bench.sv]
// Self-checking bench for enable handling and internal supervision
`timescale 1ns/1ps
module enable_and_internal_supervision_bench import sup_pkg::*;;
  localparam int PER = 8;
  localparam int WIN = 24;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] q;
  // Host drives every pin but lifesign_rx from time zero; oscillator running, enable low
  sup_in_t pin_d = '{1'b0, 1'b0, 1'b0, 1'b1, MODE_THIRD};
  sup_in_t pins;
  sup_out_t po;
  logic alive = 1'b1;
  logic ls_rx;
  logic ef;
  logic [2:0] m;
  logic [7:0] v;
  integer seed = 32'hF5D1AD6D;
  int bad_count = 0;
  int tests_run = 0;
  int ev_cnt = 0;
  int tx_cnt = 0;
  int t0;

  always_comb begin
    pins = pin_d;
    pins.lifesign_rx = ls_rx;
  end

  enable_supervisor #(.LS_PERIOD(PER), .LS_WINDOW(WIN)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins_in(pins), .pins_out(po)
  );

  secondary_model #(.PERIOD(PER)) i_sec (
    .hclk(hclk), .hresetn(hresetn), .alive(alive), .lifesign_rx(ls_rx)
  );

  initial begin
    forever #5 hclk = ~hclk;
  end

  // Counted mid-cycle, where each one-cycle pulse has settled
  always @(negedge hclk) begin
    if (po.class_a_event === 1'b1) ev_cnt++;
    if (po.lifesign_tx === 1'b1) tx_cnt++;
  end

  function automatic logic exp_flta(input logic [2:0] md, input logic prev);
    return (md == MODE_FOURTH || md == MODE_SIXTH) ? 1'b0 : prev;
  endfunction

  function automatic logic clears(input logic [2:0] md);
    return md == MODE_THIRD || md == MODE_FIFTH;
  endfunction

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang(input string what);
    bad_count++;
    $display("mismatch at %0t: no %s", $time, what);
    wrap_up();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  // Single word transfer; the slave may stretch either phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    q = hrdata;
    if (n >= 100) hang("bus answer");
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q & mask, exp);
  endtask

  task automatic wait_ev(input logic rst_ev);
    int n;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while ((rst_ev ? po.reset_event : po.class_a_event) !== 1'b1 && n < 200);
    if (n >= 200) hang("event pulse");
  endtask

  initial begin
    #500000;
    hang("end of run");
  end

  // Inputs change only at a rising edge, by non-blocking assignment
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(3);
    chk(po.reset_ready_n, 1'b1);
    rd(OFS_CONFIG, 32'hFF, {24'h0, CFG_RESET});
    rd(8'h40, 32'hFFFFFFFF, 32'h0);
    rd(OFS_STATUS, 32'hF03, 32'h100);
    t0 = tx_cnt;
    cyc(PER * 10);
    chk(tx_cnt - t0, 10);
    rd(OFS_STATUS, 32'h4, 32'h4);
    // Enable edges under random modes; expected fault level is carried along
    ef = 1'b1;
    for (int i = 0; i < 24; i++) begin
      m = 3'($random(seed));
      @(posedge hclk);
      pin_d.op_mode <= m;
      pin_d.enable_pin <= 1'b1;
      cyc(5);
      if (clears(m)) ef = 1'b1;
      chk(po.class_a_fault_n, ef);
      if (clears(m)) chk(po.class_b_fault_n, 1'b1);
      rd(OFS_STATUS, 32'h3, 32'h3);
      m = 3'($random(seed));
      // First two falls are forced into the tripping modes
      if (i == 0) m = MODE_FOURTH;
      if (i == 1) m = MODE_SIXTH;
      @(posedge hclk);
      pin_d.op_mode <= m;
      pin_d.enable_pin <= 1'b0;
      wait_ev(1'b0);
      ef = exp_flta(m, ef);
      chk(po.class_a_fault_n, ef);
      chk(po.device_disabled, 1'b1);
      rd(OFS_STATUS, 32'h3, 32'h0);
    end
    cyc(4);
    chk(ev_cnt, 24);
    // Lifesign loss wipes configuration and latches both comm errors
    v = 8'($random(seed));
    bus(1'b1, OFS_CONFIG, {24'h0, v});
    rd(OFS_CONFIG, 32'hFF, {24'h0, v});
    @(posedge hclk);
    alive <= 1'b0;
    wait_ev(1'b1);
    chk(po.class_b_fault_n, 1'b0);
    rd(OFS_ERROR, 32'h3, 32'h3);
    rd(OFS_STATUS, 32'h4, 32'h0);
    rd(OFS_CONFIG, 32'hFF, {24'h0, CFG_RESET});
    @(posedge hclk);
    alive <= 1'b1;
    cyc(3 * PER);
    rd(OFS_STATUS, 32'h4, 32'h4);
    rd(OFS_ERROR, 32'h3, 32'h3);
    bus(1'b1, OFS_CTRL, 32'h3);
    rd(OFS_ERROR, 32'h1F, 32'h0);
    chk(po.class_b_fault_n, 1'b1);
    // Primary reference failure holds the primary in reset while it lasts
    @(posedge hclk);
    pin_d.pri_ref_fault <= 1'b1;
    wait_ev(1'b1);
    chk(po.reset_ready_n, 1'b0);
    chk(po.class_b_fault_n, 1'b0);
    cyc(5);
    chk(po.bus_accept, 1'b0);
    @(posedge hclk);
    pin_d.pri_ref_fault <= 1'b0;
    cyc(2);
    chk(po.reset_ready_n, 1'b1);
    rd(OFS_ERROR, 32'h8, 32'h8);
    // Class B still low: a rise in mode four keeps it, a rise in mode five clears it
    @(posedge hclk);
    pin_d.op_mode <= MODE_FOURTH;
    pin_d.enable_pin <= 1'b1;
    cyc(5);
    chk(po.class_b_fault_n, 1'b0);
    chk(po.device_disabled, 1'b1);
    rd(OFS_STATUS, 32'h3, 32'h3);
    @(posedge hclk);
    pin_d.op_mode <= MODE_THIRD;
    pin_d.enable_pin <= 1'b0;
    wait_ev(1'b0);
    chk(po.class_a_fault_n, 1'b1);
    @(posedge hclk);
    pin_d.op_mode <= MODE_FIFTH;
    pin_d.enable_pin <= 1'b1;
    cyc(5);
    chk(po.class_b_fault_n, 1'b1);
    chk(po.device_disabled, 1'b0);
    // Oscillator absent at power-up: no register write gets through
    @(posedge hclk);
    hresetn <= 1'b0;
    pin_d.osc_running <= 1'b0;
    cyc(2);
    @(posedge hclk);
    hresetn <= 1'b1;
    cyc(3);
    chk(po.reset_ready_n, 1'b0);
    chk(po.class_b_fault_n, 1'b0);
    chk(po.sec_emergency_off, 1'b1);
    chk(po.bus_accept, 1'b0);
    bus(1'b1, OFS_CONFIG, 32'hFF);
    rd(OFS_CONFIG, 32'hFF, 32'h0);
    rd(OFS_ERROR, 32'h10, 32'h10);
    // Secondary never starts: primary runs, ready stays zero until loss is flagged
    @(posedge hclk);
    hresetn <= 1'b0;
    pin_d.osc_running <= 1'b1;
    alive <= 1'b0;
    cyc(2);
    @(posedge hclk);
    hresetn <= 1'b1;
    cyc(3);
    chk(po.bus_accept, 1'b1);
    rd(OFS_STATUS, 32'h4, 32'h0);
    wait_ev(1'b1);
    chk(po.class_b_fault_n, 1'b0);
    rd(OFS_ERROR, 32'h1, 32'h1);
    rd(OFS_STATUS, 32'h4, 32'h0);
    wrap_up();
  end
endmodule
